//--- logic/asr_baud.sv
`timescale 1ns/10ps
`include "asr_defines.svh"

// one-cycle tick at 16x the bit rate; the bit timers count 16 of these
module asr_baud #(
  parameter int CW = 20
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] prescale_sel,
  input  wire logic [2:0] rate_sel,
  input  wire logic [7:0] fine,
  output logic            tick
);
  import asr_pkg::*;

  asr_baud_s s;
  asr_baud_s next_s;

  // prescaler 1/3/4/13 times 2**rate, times fine when fine is nonzero
  function automatic logic [CW-1:0] divisor(input logic [1:0] p, input logic [2:0] r,
                                            input logic [7:0] f);
    logic [CW-1:0] d;
    case (p)
      2'h0: d = CW'(1);
      2'h1: d = CW'(3);
      2'h2: d = CW'(4);
      2'h3: d = CW'(13);
      default: d = CW'(1);
    endcase
    d = d << r;
    if (f != 8'h00)
    begin
      d = CW'(d * CW'(f));
    end
    return d;
  endfunction

  always_comb
  begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.cnt >= divisor(prescale_sel, rate_sel, fine) - CW'(1))
    begin
      next_s.cnt  = '0;
      next_s.tick = 1'b1;
    end
    else
    begin
      next_s.cnt = s.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule // asr_baud

//--- logic/asr_core.sv
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "asr_defines.svh"

// Summary of operation
// - status access then data write clears tx_empty_flag, tc
// - send-break keeps sending zero frames
// - one high bit after last break
// - enabling transmitter sends one idle frame first
// - re-enable mid-frame: idle follows, buffer dropped
// - ninth received bit goes to ctrl1
// - receive enable hunts start, lsb first
// - completed char to buffer, full flag, interrupt
// - status then data read clears full flag
// - idle frame sets flag, idle interrupt
// - full on completion: overrun, keep old data
// - start bit needs samples 8, 9, 10 all low; data bits take their majority
// - noise flag rides with full flag
// - false start discarded, noise held for later
// - missing stop bit sets framing flag
// - nonzero fine prescaler divides further
// - mute blocks receive flags and interrupts
// - idle wake clears mute, no idle flag
// - address mark wake clears mute, sets full
// - line idles high, start low, stop high
// - write when idle goes straight to shifter
module asr_core (
  // clock and reset
  input  wire logic                 CLK,
  input  wire logic                 RST_N,
  // register bus
  input  wire asr_pkg::asr_av_req_s AV_REQ,
  output logic [31:0]               AV_READDATA,
  output logic                      AV_WAITREQUEST,
  // serial line
  input  wire logic                 RX_PIN,
  output logic                      TX_PIN,
  output logic                      TX_OE,
  // cpu side
  input  wire logic                 CPU_INT_MASK,
  output logic                      IRQ
);
  import asr_pkg::*;

  localparam asr_core_s RESET_S = '{waitreq: 1'b1, txd: 1'b1, tx_empty_flag: 1'b1, tc: 1'b1,
                                    tx_st: TX_IDLE, rx_st: RX_HUNT, default: '0};

  asr_core_s s;
  asr_core_s next_s;
  logic      tx_tick;
  logic      rx_tick;

  // ----------------------------------------
  // baud generators
  // ----------------------------------------
  // baud fields are not resynchronised; changing them while enabled glitches timing
  asr_baud #(.CW(20)) u_tx_baud (
    .clk          (CLK),
    .rst_n        (RST_N),
    .prescale_sel (s.baud[7:6]),
    .rate_sel     (s.baud[5:3]),
    .fine         (s.tx_fine),
    .tick         (tx_tick)
  );

  asr_baud #(.CW(20)) u_rx_baud (
    .clk          (CLK),
    .rst_n        (RST_N),
    .prescale_sel (s.baud[7:6]),
    .rate_sel     (s.baud[2:0]),
    .fine         (s.rx_fine),
    .tick         (rx_tick)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic maj3(input logic [2:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  function automatic logic mixed3(input logic [2:0] v);
    return (v != 3'b000) && (v != 3'b111);
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    logic       req;
    logic       acc;
    logic       word9;
    logic       free;
    logic [3:0] cur;
    logic [2:0] ns;
    logic       bitv;
    logic [8:0] word;
    logic       msb;
    logic       mute;
    logic       take;
    req   = 1'b0;
    acc   = 1'b0;
    word9 = 1'b0;
    free  = 1'b0;
    cur   = 4'h0;
    ns    = 3'b000;
    bitv  = 1'b0;
    word  = 9'h000;
    msb   = 1'b0;
    mute  = 1'b0;
    take  = 1'b0;
    next_s = s;
    word9 = s.ctrl1[`ASR_C1_M];
    mute  = s.ctrl2[`ASR_C2_RWU];

    // bus: request seen with waitrequest high, accepted one cycle later
    req = AV_REQ.read | AV_REQ.write;
    acc = req & ~s.waitreq;
    next_s.waitreq = ~(req & s.waitreq);
    if (AV_REQ.read && s.waitreq)
    begin
      case (AV_REQ.address)
        `ASR_OFS_STATUS: next_s.rdata = {24'h0, s.tx_empty_flag, s.tc, s.rx_full_flag, s.idle,
                                         s.ovr, s.nf, s.fe, 1'b0};
        `ASR_OFS_DATA:   next_s.rdata = {24'h0, s.rx_buffer[7:0]};
        `ASR_OFS_CTRL1:  next_s.rdata = {24'h0, s.rx_buffer[8], s.ctrl1[6:0]};
        `ASR_OFS_CTRL2:  next_s.rdata = {24'h0, s.ctrl2};
        `ASR_OFS_BAUD:   next_s.rdata = {24'h0, s.baud};
        `ASR_OFS_RXFINE: next_s.rdata = {24'h0, s.rx_fine};
        `ASR_OFS_TXFINE: next_s.rdata = {24'h0, s.tx_fine};
        default:         next_s.rdata = 32'h0;
      endcase
    end

    if (acc)
    begin
      case (AV_REQ.address)
        `ASR_OFS_STATUS:
        begin
          next_s.sr_seen = 1'b1;
        end
        `ASR_OFS_DATA:
        begin
          if (AV_REQ.write)
          begin
            next_s.tx_buffer      = {s.ctrl1[`ASR_C1_T8], AV_REQ.writedata[7:0]};
            next_s.tdr_full = 1'b1;
            if (s.sr_seen)
            begin
              next_s.tx_empty_flag = 1'b0;
              next_s.tc   = 1'b0;
            end
          end
          else if (s.sr_seen)
          begin
            next_s.rx_full_flag = 1'b0;
            next_s.idle = 1'b0;
            next_s.ovr  = 1'b0;
            next_s.nf   = 1'b0;
            next_s.fe   = 1'b0;
          end
          next_s.sr_seen = 1'b0;
        end
        default:
        begin
        end
      endcase
      if (AV_REQ.write)
      begin
        case (AV_REQ.address)
          `ASR_OFS_CTRL1:  next_s.ctrl1   = {1'b0, AV_REQ.writedata[6:0]};
          `ASR_OFS_CTRL2:  next_s.ctrl2   = AV_REQ.writedata[7:0];
          `ASR_OFS_BAUD:   next_s.baud    = AV_REQ.writedata[7:0];
          `ASR_OFS_RXFINE: next_s.rx_fine = AV_REQ.writedata[7:0];
          `ASR_OFS_TXFINE: next_s.tx_fine = AV_REQ.writedata[7:0];
          default:         next_s.ctrl2   = next_s.ctrl2;
        endcase
      end
    end

    // ----------------------------------------
    // transmitter
    // ----------------------------------------
    next_s.te_d = s.ctrl2[`ASR_C2_TE];
    if (s.ctrl2[`ASR_C2_TE] && !s.te_d)
    begin
      next_s.pend_idle = 1'b1;
      next_s.tdr_full  = 1'b0;
    end

    case (s.tx_st)
      TX_IDLE:
      begin
        free = 1'b1;
      end
      TX_SEND:
      begin
        if (tx_tick)
        begin
          next_s.tx_sub = s.tx_sub + 4'h1;
          if (s.tx_sub == `ASR_BIT_END)
          begin
            next_s.tx_sh   = {1'b1, s.tx_sh[10:1]};
            next_s.tx_bits = s.tx_bits - 4'h1;
            if (s.tx_bits == 4'h1)
            begin
              next_s.tc = 1'b1;
              free      = 1'b1;
            end
          end
        end
      end
      default:
      begin
        free = 1'b1;
      end
    endcase

    // frame loader; runs in the cycle a frame ends so frames stay back to back
    if (free)
    begin
      next_s.tx_st   = TX_IDLE;
      next_s.tx_sub  = 4'h0;
      next_s.tx_bits = word9 ? `ASR_LEN9 : `ASR_LEN8;
      if (s.ctrl2[`ASR_C2_TE])
      begin
        next_s.tx_st = TX_SEND;
        if (next_s.pend_idle)
        begin
          next_s.tx_sh     = 11'h7ff;
          next_s.pend_idle = 1'b0;
        end
        else if (s.ctrl2[`ASR_C2_SBK])
        begin
          next_s.tx_sh    = 11'h000;
          next_s.brk_sent = 1'b1;
        end
        else if (s.brk_sent)
        begin
          next_s.tx_sh    = 11'h7ff;
          next_s.tx_bits  = 4'h1;
          next_s.brk_sent = 1'b0;
        end
        else if (next_s.tdr_full)
        begin
          // start low, data lsb first, stop high
          next_s.tx_sh = word9 ? {1'b1, next_s.tx_buffer, 1'b0}
                               : {2'b11, next_s.tx_buffer[7:0], 1'b0};
          next_s.tdr_full = 1'b0;
          next_s.tx_empty_flag     = 1'b1;
        end
        else
        begin
          next_s.tx_st = TX_IDLE;
        end
      end
    end

    // ----------------------------------------
    // receiver
    // ----------------------------------------
    next_s.re_d = s.ctrl2[`ASR_C2_RE];
    if (!s.ctrl2[`ASR_C2_RE])
    begin
      next_s.rx_st    = RX_HUNT;
      next_s.hist     = 3'b000;
      next_s.idle_cnt = 8'h00;
    end
    else
    begin
      if (!s.re_d)
      begin
        next_s.idle_arm = 1'b1;
      end
      if (rx_tick)
      begin
        cur = s.rx_sub + 4'h1;
        ns  = {s.smp[1:0], RX_PIN};
        case (s.rx_st)
          RX_HUNT:
          begin
            next_s.hist     = {s.hist[1:0], RX_PIN};
            next_s.idle_cnt = RX_PIN ? s.idle_cnt + {7'h0, s.idle_cnt != 8'hff} : 8'h00;
            if (s.idle_arm && RX_PIN &&
                (s.idle_cnt == (word9 ? `ASR_IDLE9 : `ASR_IDLE8)))
            begin
              next_s.idle_arm = 1'b0;
              if (mute && !s.ctrl1[`ASR_C1_WAKE])
              begin
                next_s.ctrl2[`ASR_C2_RWU] = 1'b0;
              end
              else if (!mute)
              begin
                next_s.idle = 1'b1;
              end
            end
            if (s.hist == 3'b111 && !RX_PIN)
            begin
              next_s.rx_st  = RX_START;
              next_s.rx_sub = 4'h0;
              next_s.noise  = 1'b0;
              next_s.smp    = 3'b000;
            end
          end
          RX_START:
          begin
            next_s.rx_sub = cur;
            if ((cur == `ASR_SMP3 || cur == `ASR_SMP5 || cur == `ASR_SMP7) && RX_PIN)
            begin
              next_s.noise = 1'b1;
            end
            if (cur >= `ASR_SMP8 && cur <= `ASR_SMP10)
            begin
              next_s.smp = ns;
            end
            if (cur == `ASR_SMP10 && ns != 3'b000)
            begin
              // glitch, not a start bit: drop it, keep the noise for later
              next_s.pend_nf = 1'b1;
              next_s.rx_st   = RX_HUNT;
              next_s.hist    = 3'b000;
            end
            if (cur == `ASR_BIT_END)
            begin
              next_s.rx_st   = RX_DATA;
              next_s.rx_sub  = 4'hf; // next tick is sample one of data bit 0, as in the start bit
              next_s.rx_bits = 4'h0;
            end
          end
          RX_DATA:
          begin
            next_s.rx_sub = cur;
            if (cur >= `ASR_SMP8 && cur <= `ASR_SMP10)
            begin
              next_s.smp = ns;
            end
            if (cur == `ASR_SMP10)
            begin
              bitv = maj3(ns);
              if (mixed3(ns))
              begin
                next_s.noise = 1'b1;
              end
              if (s.rx_bits != (word9 ? 4'd9 : 4'd8))
              begin
                next_s.rx_sh   = {bitv, s.rx_sh[8:1]};
                next_s.rx_bits = s.rx_bits + 4'h1;
              end
              else
              begin
                // stop bit judged at its middle; rest of it is hunt time
                word = word9 ? s.rx_sh : {1'b0, s.rx_sh[8:1]};
                msb  = word9 ? word[8] : word[7];
                take = !mute;
                if (mute && s.ctrl1[`ASR_C1_WAKE] && msb)
                begin
                  next_s.ctrl2[`ASR_C2_RWU] = 1'b0;
                  take = 1'b1;
                end
                if (take)
                begin
                  if (next_s.rx_full_flag)
                  begin
                    next_s.ovr = 1'b1;
                  end
                  else
                  begin
                    next_s.rx_buffer     = word;
                    next_s.rx_full_flag    = 1'b1;
                    next_s.nf      = next_s.noise | s.pend_nf;
                    next_s.fe      = ~bitv;
                    next_s.pend_nf = 1'b0;
                  end
                end
                next_s.rx_st    = RX_HUNT;
                next_s.hist     = {3{bitv}}; // a low stop is no high history for the next edge
                next_s.idle_cnt = 8'h00;
                next_s.idle_arm = 1'b1;
              end
            end
          end
          default:
          begin
            next_s.rx_st = RX_HUNT;
          end
        endcase
      end
    end

    // ----------------------------------------
    // pins and interrupt request
    // ----------------------------------------
    next_s.txd = (next_s.tx_st == TX_SEND) ? next_s.tx_sh[0] : 1'b1;
    next_s.oe  = next_s.ctrl2[`ASR_C2_TE] | next_s.ctrl2[`ASR_C2_RE];
    next_s.irq = ~CPU_INT_MASK &
                 ((next_s.tx_empty_flag & next_s.ctrl2[`ASR_C2_TIE]) |
                  (next_s.tc & next_s.ctrl2[`ASR_C2_TCIE]) |
                  (~next_s.ctrl2[`ASR_C2_RWU] &
                   (((next_s.rx_full_flag | next_s.ovr) & next_s.ctrl2[`ASR_C2_RIE]) |
                    (next_s.idle & next_s.ctrl2[`ASR_C2_IDLE_INT_ENABLE]))));
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      s <= RESET_S;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign AV_READDATA    = s.rdata;
  assign AV_WAITREQUEST = s.waitreq;
  assign TX_PIN         = s.txd;
  assign TX_OE          = s.oe;
  assign IRQ            = s.irq;

endmodule // asr_core

//--- logic/asr_defines.svh
`ifndef ASR_DEFINES_SVH
`define ASR_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ASR_OFS_STATUS 5'h00
`define ASR_OFS_DATA   5'h04
`define ASR_OFS_CTRL1  5'h08
`define ASR_OFS_CTRL2  5'h0c
`define ASR_OFS_BAUD   5'h10
`define ASR_OFS_RXFINE 5'h14
`define ASR_OFS_TXFINE 5'h18

// ----------------------------------------
// field positions
// ----------------------------------------
`define ASR_C1_R8   7
`define ASR_C1_T8   6
`define ASR_C1_M    4
`define ASR_C1_WAKE 3
`define ASR_C2_TIE  7
`define ASR_C2_TCIE 6
`define ASR_C2_RIE  5
`define ASR_C2_IDLE_INT_ENABLE 4
`define ASR_C2_TE   3
`define ASR_C2_RE   2
`define ASR_C2_RWU  1
`define ASR_C2_SBK  0

// ----------------------------------------
// reset values
// ----------------------------------------
`define ASR_STATUS_RST 8'hc0
`define ASR_CTRL_RST   8'h00

// ----------------------------------------
// timing, in oversample ticks (16 per bit); frame lengths in bits
// ----------------------------------------
`define ASR_SMP3    4'h2
`define ASR_SMP5    4'h4
`define ASR_SMP7    4'h6
`define ASR_SMP8    4'h7
`define ASR_SMP10   4'h9
`define ASR_BIT_END 4'hf
`define ASR_IDLE8   8'd159
`define ASR_IDLE9   8'd175
`define ASR_LEN8    4'd10
`define ASR_LEN9    4'd11

`endif

//--- logic/asr_pkg.sv
package asr_pkg;

  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} asr_tx_e;
  typedef enum logic [2:0] {RX_HUNT = 3'b001, RX_START = 3'b010, RX_DATA = 3'b100} asr_rx_e;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
  } asr_av_req_s;

  typedef struct packed {
    logic [19:0] cnt;
    logic        tick;
  } asr_baud_s;

  typedef struct packed {
    logic        waitreq;
    logic [31:0] rdata;
    logic        irq;
    logic        txd;
    logic        oe;
    logic [7:0]  ctrl1;
    logic [7:0]  ctrl2;
    logic [7:0]  baud;
    logic [7:0]  rx_fine;
    logic [7:0]  tx_fine;
    logic        tx_empty_flag;
    logic        tc;
    logic        rx_full_flag;
    logic        idle;
    logic        ovr;
    logic        nf;
    logic        fe;
    logic        sr_seen;
    logic [8:0]  tx_buffer;
    logic        tdr_full;
    logic        pend_idle;
    logic        brk_sent;
    logic        te_d;
    logic        re_d;
    asr_tx_e     tx_st;
    logic [10:0] tx_sh;
    logic [3:0]  tx_bits;
    logic [3:0]  tx_sub;
    asr_rx_e     rx_st;
    logic [2:0]  hist;
    logic [3:0]  rx_sub;
    logic [3:0]  rx_bits;
    logic [8:0]  rx_sh;
    logic [2:0]  smp;
    logic        noise;
    logic        pend_nf;
    logic [8:0]  rx_buffer;
    logic [7:0]  idle_cnt;
    logic        idle_arm;
  } asr_core_s;

endpackage

//--- tb/asr_core_props.sv
`timescale 1ns/10ps
`include "asr_defines.svh"
module asr_core_props (
  // clock and reset
  input wire logic                 CLK,
  input wire logic                 RST_N,
  // register bus
  input wire asr_pkg::asr_av_req_s AV_REQ,
  input wire logic [31:0]          AV_READDATA,
  input wire logic                 AV_WAITREQUEST,
  // line and cpu
  input wire logic                 RX_PIN,
  input wire logic                 TX_PIN,
  input wire logic                 TX_OE,
  input wire logic                 CPU_INT_MASK,
  input wire logic                 IRQ
);
  import asr_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire req_seen = (AV_REQ.read || AV_REQ.write) && AV_WAITREQUEST;
  wire rd_hole  = req_seen && AV_REQ.read && AV_REQ.address == 5'h1c;
  wire wr_ctrl2 = req_seen && AV_REQ.write && AV_REQ.address == `ASR_OFS_CTRL2;
  // ----
  // sequences
  // ----
  // 16 cycles is the shortest bit, reached with every divider at one
  sequence low16;
    !TX_PIN [*8] ##1 !TX_PIN [*8];
  endsequence
  sequence high16;
    TX_PIN [*8] ##1 TX_PIN [*8];
  endsequence
  // ----
  // properties
  // ----
  ack_one_cycle_a: assert property (req_seen |=> !AV_WAITREQUEST ##1 AV_WAITREQUEST)
    else $error("bus answer not one cycle");
  no_stray_ack_a: assert property ($fell(AV_WAITREQUEST) |-> $past(req_seen))
    else $error("answer without request");
  upper_zero_a: assert property (!AV_WAITREQUEST |-> AV_READDATA[31:8] == 24'h0)
    else $error("upper read bits not zero");
  unmapped_zero_a: assert property (rd_hole |=> AV_READDATA == 32'h0)
    else $error("unmapped read not zero");
  irq_masked_a: assert property (CPU_INT_MASK ##1 CPU_INT_MASK |-> !IRQ)
    else $error("irq while masked");
  start_bit_a: assert property ($fell(TX_PIN) |-> low16)
    else $error("start bit too short");
  idle_first_a: assert property ($rose(TX_OE) |-> high16)
    else $error("no idle frame after enable");
  oe_follows_a: assert property (wr_ctrl2 |=> ##1 TX_OE == $past(|AV_REQ.writedata[3:2], 2))
    else $error("output enable not following enables");
endmodule // asr_core_props

bind asr_core asr_core_props u_props (
  .CLK(CLK), .RST_N(RST_N), .AV_REQ(AV_REQ), .AV_READDATA(AV_READDATA),
  .AV_WAITREQUEST(AV_WAITREQUEST), .RX_PIN(RX_PIN), .TX_PIN(TX_PIN), .TX_OE(TX_OE),
  .CPU_INT_MASK(CPU_INT_MASK), .IRQ(IRQ)
);

//--- tb/asr_remote.sv
`timescale 1ns/10ps
module asr_remote (
  // clock
  input wire logic CLK,
  // line
  input wire logic TX_PIN,
  output logic     RX_PIN
);
  int         bit_cyc = 16;
  logic [8:0] got[$];
  initial RX_PIN = 1'b1;
  // ----
  // sender, line idles high between frames
  // ----
  task automatic send(input logic [8:0] d, input int n, input int gl, input logic stp);
    logic b;
    for (int i = 0; i <= n + 1; i++)
    begin
      b = (i == 0) ? 1'b0 : (i > n) ? stp : d[i-1];
      for (int c = 0; c < bit_cyc; c++)
      begin
        @(posedge CLK);
        RX_PIN <= (gl > 0 && i == gl && c == 8) ? !b : b; // glitch hits sample 9 only
      end
    end
    @(posedge CLK);
    RX_PIN <= 1'b1;
  endtask
  task automatic pulse(input int len);
    @(posedge CLK);
    RX_PIN <= 1'b0;
    repeat (len) @(posedge CLK);
    RX_PIN <= 1'b1;
  endtask
  // ----
  // listener, keeps {stop, data}
  // ----
  initial
  begin : listen
    logic [8:0] w;
    forever
    begin
      @(negedge TX_PIN);
      repeat (bit_cyc / 2) @(posedge CLK);
      for (int i = 0; i < 9; i++)
      begin
        repeat (bit_cyc) @(posedge CLK);
        w[i] = TX_PIN;
      end
      got.push_back(w);
      // a break holds the line low, so wait for it to rise again
      wait (TX_PIN === 1'b1);
    end
  end
endmodule // asr_remote

//--- tb/testbench.sv
`timescale 1ns/10ps
`include "asr_defines.svh"
module testbench;
  import asr_pkg::*;
  localparam logic [4:0] st = `ASR_OFS_STATUS;
  localparam logic [4:0] dt = `ASR_OFS_DATA;
  localparam logic [4:0] c1 = `ASR_OFS_CTRL1;
  localparam logic [4:0] c2 = `ASR_OFS_CTRL2;
  logic        clk, rst_n, int_mask, waitreq, rx_pin, tx_pin, tx_oe, irq;
  asr_av_req_s req;
  logic [31:0] rdata, v;
  int          bad_count = 0;
  int          n_tests = 0;
  logic [7:0]  bds[3] = '{8'h40, 8'h00, 8'h00};
  logic [7:0]  fns[3] = '{8'h00, 8'h02, 8'h00};
  int          bcs[3] = '{48, 32, 16};
  asr_core DUT (
    .CLK(clk), .RST_N(rst_n), .AV_REQ(req), .AV_READDATA(rdata), .AV_WAITREQUEST(waitreq),
    .RX_PIN(rx_pin), .TX_PIN(tx_pin), .TX_OE(tx_oe), .CPU_INT_MASK(int_mask), .IRQ(irq)
  );
  asr_remote far (.CLK(clk), .TX_PIN(tx_pin), .RX_PIN(rx_pin));
  // ----
  // tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic access(input logic w, input logic [4:0] a, input logic [7:0] d);
    int t;
    t = 0;
    @(posedge clk);
    req <= '{read: !w, write: w, address: a, writedata: {24'h0, d}};
    // hold until waitrequest is sampled low; only the watchdog ends a hung wait
    do
    begin
      @(posedge clk);
      t++;
    end
    while (waitreq !== 1'b0);
    v = rdata;
    chk("bus answer", t, 32'd2); // one wait cycle, then the answer edge
    req <= '0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    access(1'b1, a, d);
  endtask
  task automatic rd(input logic [4:0] a);
    access(1'b0, a, 8'h00);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rx_case(input logic [8:0] d, input int n, input int gl, input logic stp,
                         input logic [7:0] sv, input logic [7:0] dv);
    far.send(d, n, gl, stp);
    cyc(20);
    rd(st);
    chk("rx status", v & 32'h3e, {24'h0, sv});
    rd(dt);
    chk("rx data", v, {24'h0, dv});
  endtask
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ----
  // clock, watchdog, tests
  // ----
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    bad_count++;
    complete_run();
  end
  initial
  begin
    rst_n = 1'b0;
    int_mask = 1'b0;
    req = '0;
    cyc(4);
    rst_n <= 1'b1;
    rd(st);
    chk("status reset", v, 32'hc0);
    rd(c2);
    chk("ctrl2 reset", v, 32'h0);
    wr(5'h1c, 8'hff);
    rd(5'h1c);
    chk("unmapped", v, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      wr(c2, 8'h00); // divider changes only while disabled
      wr(`ASR_OFS_BAUD, bds[i]);
      wr(`ASR_OFS_TXFINE, fns[i]);
      far.bit_cyc = bcs[i];
      wr(c2, 8'h08);
      cyc(12 * bcs[i]);
      rd(st);
      wr(dt, 8'h5a + i[7:0]);
      rd(st);
      chk("tx flags", v & 32'hc0, 32'h80);
      cyc(12 * bcs[i]);
      chk("tx frame", far.got.pop_front(), {1'b1, 8'h5a + i[7:0]});
      rd(st);
      chk("tx done", v & 32'hc0, 32'hc0);
    end
    wr(c2, 8'h09);
    rd(st);
    wr(dt, 8'hc3);
    cyc(400);
    wr(c2, 8'h08);
    cyc(600);
    chk("break", far.got.pop_front(), 32'h0);
    chk("after break", far.got.pop_front(), {1'b1, 8'hc3});
    wr(c2, 8'h0c);
    cyc(200);
    rd(st);
    wr(dt, 8'h71);
    wr(dt, 8'h72);
    wr(c2, 8'h04);
    wr(c2, 8'h0c);
    cyc(600);
    chk("dropped", far.got.size(), 1);
    chk("kept", far.got.pop_front(), {1'b1, 8'h71});
    wr(c2, 8'h08);
    rd(st);
    rd(dt);
    wr(c2, 8'h2c);
    cyc(4); // receiver needs three high samples before a start edge
    far.send(9'h03c, 8, 0, 1'b1);
    cyc(20);
    chk("rx irq", {31'h0, irq}, 32'h1);
    rd(dt);
    chk("rx byte", v, 32'h3c);
    rd(st);
    chk("unqualified read", v & 32'h3e, 32'h20);
    rd(dt);
    rd(st);
    chk("rx cleared", v & 32'h3e, 32'h0);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    int_mask <= 1'b1;
    far.send(9'h0a1, 8, 0, 1'b1);
    chk("masked irq", {31'h0, irq}, 32'h0);
    rx_case(9'h0a2, 8, 0, 1'b1, 8'h28, 8'ha1);
    int_mask <= 1'b0;
    rd(st);
    chk("overrun cleared", v & 32'h3e, 32'h0);
    rx_case(9'h0a5, 8, 3, 1'b1, 8'h24, 8'ha5);
    rx_case(9'h000, 8, 0, 1'b0, 8'h22, 8'h00);
    far.pulse(6);
    cyc(40);
    rd(st);
    chk("false start", v & 32'h3e, 32'h0);
    rx_case(9'h033, 8, 0, 1'b1, 8'h24, 8'h33);
    wr(c1, 8'h10);
    rx_case(9'h155, 9, 0, 1'b1, 8'h20, 8'h55);
    rd(c1);
    chk("ninth bit", v & 32'h80, 32'h80);
    wr(c1, 8'h08);
    wr(c2, 8'h2e);
    far.send(9'h011, 8, 0, 1'b1);
    cyc(20);
    rd(st);
    chk("muted", v & 32'h3e, 32'h0);
    chk("muted irq", {31'h0, irq}, 32'h0);
    rx_case(9'h091, 8, 0, 1'b1, 8'h20, 8'h91);
    rd(c2);
    chk("mark wake", v & 32'h02, 32'h0);
    wr(c1, 8'h00);
    wr(c2, 8'h36); // written only once awake
    cyc(300);
    rd(c2);
    chk("idle wake", v & 32'h02, 32'h0);
    rd(st);
    chk("no idle flag", v & 32'h3e, 32'h0);
    rx_case(9'h07e, 8, 0, 1'b1, 8'h20, 8'h7e);
    cyc(250);
    chk("idle irq", {31'h0, irq}, 32'h1);
    rd(st);
    chk("idle flag", v & 32'h10, 32'h10);
    complete_run();
  end
endmodule // testbench
